/* File: core/snr_pkg.sv */
// Purpose: Shared constants, opcodes, states and command decode for the read path.
// Assumes: 256 Mbit array (25 address bits), byte-wide array port.
// Notes: The decode function is pure logic and is also used by the assertions.
package snr_pkg;

  // Read opcodes, 3-byte forms and 4-byte forms
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_READ4 = 8'h13;
  localparam logic [7:0] OP_FAST = 8'h0b;
  localparam logic [7:0] OP_FAST4 = 8'h0c;
  localparam logic [7:0] OP_DOUT = 8'h3b;
  localparam logic [7:0] OP_DOUT4 = 8'h3c;
  localparam logic [7:0] OP_DIO = 8'hbb;
  localparam logic [7:0] OP_DIO4 = 8'hbc;
  localparam logic [7:0] OP_QOUT = 8'h6b;
  localparam logic [7:0] OP_QOUT4 = 8'h6c;
  localparam logic [7:0] OP_QIO = 8'heb;
  localparam logic [7:0] OP_QIO4 = 8'hec;
  localparam logic [7:0] OP_DTR = 8'h0d;
  localparam logic [7:0] OP_DTR_DOUT = 8'h3d;
  localparam logic [7:0] OP_DTR_DIO = 8'hbd;
  localparam logic [7:0] OP_DTR_QOUT = 8'h6d;
  localparam logic [7:0] OP_DTR_QIO = 8'hed;
  localparam logic [7:0] OP_DTR4 = 8'h0e;
  localparam logic [7:0] OP_DTR4_DIO = 8'hbe;
  localparam logic [7:0] OP_DTR4_QIO = 8'hee;
  localparam logic [7:0] OP_WORD = 8'he7;

  typedef enum logic [1:0] {
    SNR_EXT = 2'h0,
    SNR_DUAL = 2'h1,
    SNR_QUAD = 2'h2
  } snr_proto_t;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_OPC = 6'h02,
    ST_ADDR = 6'h04,
    ST_DUMMY = 6'h08,
    ST_DATA = 6'h10,
    ST_IGN = 6'h20
  } snr_state_t;

  // Active data line counts
  localparam logic [2:0] L1 = 3'h1;
  localparam logic [2:0] L2 = 3'h2;
  localparam logic [2:0] L4 = 3'h4;

  localparam int ADDR_W = 25;
  localparam logic [ADDR_W-1:0] MEM_LAST = 25'h1ffffff;
  localparam logic [ADDR_W-1:0] MEM_FIRST = 25'h0000000;
  localparam int FIFO_W = 8;
  localparam int FIFO_D = 16;
  localparam logic [5:0] BITS_OPC = 6'h08;
  localparam logic [5:0] BITS_3B = 6'h18;
  localparam logic [5:0] BITS_4B = 6'h20;
  localparam logic [3:0] OUT_BYTE = 4'h8;
  localparam logic [3:0] DUMMY_DFLT = 4'h8;
  localparam logic [3:0] DUMMY_WORD = 4'h4;
  localparam logic [3:0] DUMMY_NONE = 4'h0;

  // Synchroniser lanes: bit 0 serial clock, bit 1 chip select, bits 5:2 data lines
  localparam int SYNC_W = 6;
  localparam logic [SYNC_W-1:0] SYNC_IDLE = 6'h02;
  localparam int SY_CLK = 0;
  localparam int SY_CS = 1;
  localparam int SY_DQ = 2;

  // Output enables per data width; single-line data leaves on line 1
  localparam logic [3:0] OE_1 = 4'h2;
  localparam logic [3:0] OE_2 = 4'h3;
  localparam logic [3:0] OE_4 = 4'hf;

  typedef struct packed {
    logic ok;
    logic force4;
    logic dtr;
    logic fast;
    logic word;
    logic io;
    logic [2:0] lines;
  } snr_cmd_t;

  function automatic snr_cmd_t snr_decode(input logic [7:0] op);
    snr_cmd_t c;
    c = '{ok: 1'b1, force4: 1'b0, dtr: 1'b0, fast: 1'b1, word: 1'b0, io: 1'b0, lines: L1};
    case (op)
      OP_READ: c.fast = 1'b0;
      OP_READ4: begin
        c.fast = 1'b0;
        c.force4 = 1'b1;
      end
      OP_FAST: c.lines = L1;
      OP_FAST4: c.force4 = 1'b1;
      OP_DOUT: c.lines = L2;
      OP_DOUT4: begin
        c.lines = L2;
        c.force4 = 1'b1;
      end
      OP_DIO: begin
        c.lines = L2;
        c.io = 1'b1;
      end
      OP_DIO4: begin
        c.lines = L2;
        c.io = 1'b1;
        c.force4 = 1'b1;
      end
      OP_QOUT: c.lines = L4;
      OP_QOUT4: begin
        c.lines = L4;
        c.force4 = 1'b1;
      end
      OP_QIO: begin
        c.lines = L4;
        c.io = 1'b1;
      end
      OP_QIO4: begin
        c.lines = L4;
        c.io = 1'b1;
        c.force4 = 1'b1;
      end
      OP_DTR: c.dtr = 1'b1;
      OP_DTR_DOUT: begin
        c.dtr = 1'b1;
        c.lines = L2;
      end
      OP_DTR_DIO: begin
        c.dtr = 1'b1;
        c.lines = L2;
        c.io = 1'b1;
      end
      OP_DTR_QOUT: begin
        c.dtr = 1'b1;
        c.lines = L4;
      end
      OP_DTR_QIO: begin
        c.dtr = 1'b1;
        c.lines = L4;
        c.io = 1'b1;
      end
      OP_DTR4: begin
        c.dtr = 1'b1;
        c.force4 = 1'b1;
      end
      OP_DTR4_DIO: begin
        c.dtr = 1'b1;
        c.lines = L2;
        c.io = 1'b1;
        c.force4 = 1'b1;
      end
      OP_DTR4_QIO: begin
        c.dtr = 1'b1;
        c.lines = L4;
        c.io = 1'b1;
        c.force4 = 1'b1;
      end
      OP_WORD: begin
        c.lines = L4;
        c.io = 1'b1;
        c.word = 1'b1;
      end
      default: c.ok = 1'b0;
    endcase
    return c;
  endfunction

endpackage

/* File: core/snr_read_path.sv */
// Purpose: Read-command path of a serial NOR flash, from opcode to streamed array data.
// Assumes: Serial clock, chip select and data lines are asynchronous and much slower than clk.
// Notes: Array bytes are prefetched into a FIFO so the shifter never waits on the array.
//
// What this block does
// - Chip select high at any time ends the read; device stops driving.
// - Ordinary reads take a 24-bit address by default.
// - Decode 03h basic read and 13h basic read with 4-byte address.
// - Decode 0Bh fast read and 0Ch fast read with 4-byte address.
// - Decode 3Bh/3Ch dual-output fast reads; data on two lines.
// - Decode BBh/BCh dual I/O fast reads; address and data on two lines.
// - Decode 6Bh/6Ch quad-output fast reads; data on four lines.
// - Decode EBh/ECh quad I/O fast reads; address and data on four lines.
// - Decode 3-byte both-edge reads 0Dh, 3Dh, BDh, 6Dh, EDh.
// - Decode 4-byte both-edge reads 0Eh, BEh, EEh.
// - Both-edge opcodes always run both-edge, whatever configuration says.
// - Other reads run both-edge only when configuration enables it.
// - Address bits are captured on serial clock rising edges, or on both edges for both-edge reads.
// - Output starts at any byte; address increments after each byte.
// - Address wraps to zero past the last array location.
// - Word read E7h uses the address as sent, with no even alignment forced, and exactly four dummy clocks.
// - Word read works in extended or quad, single-edge only; ignored in dual.
// - 4-byte reads take a full 32-bit address.
// - Address width set from nonvolatile setting or enter/exit commands.
// - 4-byte opcodes always take four address bytes; others follow configuration.
// - Opcode takes 8, 4 or 2 clocks, half that when configuration enables both-edge; address uses same lines, except I/O opcodes in extended, which use 2 or 4.
// - In 4-byte mode ordinary reads also take four address bytes.
// - Dummy count comes from nonvolatile setting, overridden by volatile setting.
// - Dual/quad protocol opcodes use 2/4 lines; both-edge samples both edges.
`timescale 1ns/1ps

module snr_fifo #(
  parameter int W = snr_pkg::FIFO_W,
  parameter int D = snr_pkg::FIFO_D
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW:0] wr_q;
  logic [AW:0] rd_q;
  logic push;
  logic pop;

  assign in_ready = (wr_q - rd_q) != (AW+1)'(D);
  assign out_valid = wr_q != rd_q;
  assign out_data = mem[rd_q[AW-1:0]];
  assign push = in_valid && in_ready && !flush;
  assign pop = out_valid && out_ready && !flush;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_q[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wr_q <= '0;
      rd_q <= '0;
    end else if (flush) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      wr_q <= wr_q + (AW+1)'(push);
      rd_q <= rd_q + (AW+1)'(pop);
    end
  end
endmodule // snr_fifo

module snr_read_path (
  input wire logic clk,
  input wire logic nrst,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic [3:0] serial_io_lines_rx,
  output logic [3:0] serial_io_lines_drv,
  output logic [3:0] serial_io_lines_en,
  input wire snr_pkg::snr_proto_t proto,
  input wire logic dtr_en,
  input wire logic addr4_nv,
  input wire logic addr4_enter,
  input wire logic addr4_exit,
  input wire logic [3:0] dummy_nv,
  input wire logic [3:0] dummy_vol,
  input wire logic dummy_vol_set,
  output logic array_rd,
  output logic [snr_pkg::ADDR_W-1:0] array_addr,
  input wire logic [snr_pkg::FIFO_W-1:0] array_data,
  output logic busy
);
  import snr_pkg::*;

  logic [SYNC_W-1:0] s1_q, s2_q, s3_q, lvl_q, lvl_d;
  logic rise, fall, cs_hi, smp;
  logic [3:0] dq;
  snr_state_t state_q;
  snr_cmd_t cmd, cmd_q;
  logic [31:0] in_sr_q, in_sr_d;
  logic [5:0] bit_cnt_q, cnt_nx, addr_bits_q;
  logic [2:0] lines_q, data_lines_q, plines;
  logic dtr_q, addr4_q, loaded_q, addr_done, opc_done;
  logic [3:0] dummy_cfg, dummy_q, dummy_sel;
  logic [ADDR_W-1:0] fetch_addr_q;
  logic fetch_on_q, rd_q, push_q;
  logic [ADDR_W-1:0] array_addr_q;
  logic fifo_in_ready, fifo_out_valid, fifo_pop;
  logic [FIFO_W-1:0] fifo_data;
  logic [7:0] out_sr_q, src;
  logic [3:0] out_cnt_q;
  logic [3:0] drv_q, en_q, drv_d, en_d;
  logic out_edge, busy_q;

  // Three-stage synchronisers; a lane moves only once stages two and three agree
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s1_q <= SYNC_IDLE;
      s2_q <= SYNC_IDLE;
      s3_q <= SYNC_IDLE;
      lvl_q <= SYNC_IDLE;
    end else begin
      s1_q <= {serial_io_lines_rx, cs_n, sclk};
      s2_q <= s1_q;
      s3_q <= s2_q;
      lvl_q <= lvl_d;
    end
  end

  always_comb begin
    for (int i = 0; i < SYNC_W; i++) begin
      lvl_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : lvl_q[i];
    end
  end

  assign rise = lvl_d[SY_CLK] && !lvl_q[SY_CLK];
  assign fall = !lvl_d[SY_CLK] && lvl_q[SY_CLK];
  assign cs_hi = lvl_d[SY_CS];
  assign dq = lvl_d[SY_DQ +: 4];
  // Single-edge captures on rising edges only; both-edge captures on either
  assign smp = rise || (dtr_q && fall);

  assign plines = (proto == SNR_QUAD) ? L4 : ((proto == SNR_DUAL) ? L2 : L1);
  assign cnt_nx = bit_cnt_q + {3'h0, lines_q};
  assign cmd = snr_decode(in_sr_d[7:0]);

  always_comb begin
    case (lines_q)
      L1: in_sr_d = {in_sr_q[30:0], dq[0]};
      L2: in_sr_d = {in_sr_q[29:0], dq[1:0]};
      default: in_sr_d = {in_sr_q[27:0], dq};
    endcase
  end

  // Address width: nonvolatile value caught once after reset, then commands steer it
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      loaded_q <= 1'b0;
      addr4_q <= 1'b0;
    end else if (!loaded_q) begin
      loaded_q <= 1'b1;
      addr4_q <= addr4_nv;
    end else if (addr4_enter) begin
      addr4_q <= 1'b1;
    end else if (addr4_exit) begin
      addr4_q <= 1'b0;
    end
  end

  // Zero in the setting selects the default count
  assign dummy_cfg = dummy_vol_set ? dummy_vol : dummy_nv;
  assign dummy_sel = cmd_q.word ? DUMMY_WORD :
                     (!cmd_q.fast ? DUMMY_NONE :
                     ((dummy_cfg == DUMMY_NONE) ? DUMMY_DFLT : dummy_cfg));

  assign opc_done = (state_q == ST_OPC) && smp && (cnt_nx == BITS_OPC);
  assign addr_done = (state_q == ST_ADDR) && smp && (cnt_nx == addr_bits_q);

  // Command sequencer; deselect wins over everything
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= ST_IDLE;
      cmd_q <= '0;
      in_sr_q <= '0;
      bit_cnt_q <= '0;
      addr_bits_q <= BITS_3B;
      lines_q <= L1;
      data_lines_q <= L1;
      dtr_q <= 1'b0;
      dummy_q <= DUMMY_NONE;
    end else if (cs_hi) begin
      state_q <= ST_IDLE;
      bit_cnt_q <= '0;
      dtr_q <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          state_q <= ST_OPC;
          lines_q <= plines;
          dtr_q <= dtr_en;
          bit_cnt_q <= '0;
        end
        ST_OPC: begin
          if (smp) begin
            in_sr_q <= in_sr_d;
            bit_cnt_q <= cnt_nx;
          end
          if (opc_done) begin
            bit_cnt_q <= '0;
            cmd_q <= cmd;
            // Opcode bits must not leak into the top of a 24-bit address
            in_sr_q <= '0;
            if (!cmd.ok || (cmd.word && (proto == SNR_DUAL || dtr_en))) begin
              state_q <= ST_IGN;
            end else begin
              state_q <= ST_ADDR;
              dtr_q <= dtr_en || cmd.dtr;
              addr_bits_q <= (cmd.force4 || addr4_q) ? BITS_4B : BITS_3B;
              lines_q <= (proto == SNR_EXT) ? (cmd.io ? cmd.lines : L1) : plines;
              data_lines_q <= (proto == SNR_EXT) ? cmd.lines : plines;
            end
          end
        end
        ST_ADDR: begin
          if (smp) begin
            in_sr_q <= in_sr_d;
            bit_cnt_q <= cnt_nx;
          end
          if (addr_done) begin
            dummy_q <= dummy_sel;
            state_q <= (dummy_sel == DUMMY_NONE) ? ST_DATA : ST_DUMMY;
          end
        end
        ST_DUMMY: begin
          // Dummies count whole clocks, so only rising edges matter here
          if (rise) begin
            dummy_q <= dummy_q - 4'h1;
            if (dummy_q == 4'h1) begin
              state_q <= ST_DATA;
            end
          end
        end
        ST_DATA: state_q <= ST_DATA;
        ST_IGN: state_q <= ST_IGN;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Array prefetch: one read in flight, stalled by a full FIFO
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      fetch_on_q <= 1'b0;
      fetch_addr_q <= MEM_FIRST;
      rd_q <= 1'b0;
      push_q <= 1'b0;
      array_addr_q <= MEM_FIRST;
    end else if (cs_hi) begin
      fetch_on_q <= 1'b0;
      rd_q <= 1'b0;
      push_q <= 1'b0;
    end else begin
      push_q <= rd_q;
      rd_q <= 1'b0;
      if (addr_done) begin
        fetch_on_q <= 1'b1;
        fetch_addr_q <= in_sr_d[ADDR_W-1:0];
      end else if (fetch_on_q && !rd_q && !push_q && fifo_in_ready) begin
        rd_q <= 1'b1;
        array_addr_q <= fetch_addr_q;
        fetch_addr_q <= (fetch_addr_q == MEM_LAST) ? MEM_FIRST : fetch_addr_q + 25'h1;
      end
    end
  end

  snr_fifo #(.W(FIFO_W), .D(FIFO_D)) u_fifo (
    .clk(clk),
    .nrst(nrst),
    .flush(cs_hi),
    .in_valid(push_q),
    .in_ready(fifo_in_ready),
    .in_data(array_data),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_data)
  );

  // Single-edge data changes on falling edges so the host samples on rising ones
  assign out_edge = (state_q == ST_DATA) && (fall || (dtr_q && rise));
  assign fifo_pop = out_edge && (out_cnt_q == 4'h0) && fifo_out_valid;
  // An empty FIFO at a byte boundary shows zeros; prefetch outruns the link by far
  assign src = (out_cnt_q == 4'h0) ? (fifo_out_valid ? fifo_data : 8'h00) : out_sr_q;

  always_comb begin
    case (data_lines_q)
      L1: begin
        drv_d = {2'h0, src[7], 1'b0};
        en_d = OE_1;
      end
      L2: begin
        drv_d = {2'h0, src[7:6]};
        en_d = OE_2;
      end
      default: begin
        drv_d = src[7:4];
        en_d = OE_4;
      end
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      drv_q <= 4'h0;
      en_q <= 4'h0;
      out_sr_q <= 8'h00;
      out_cnt_q <= 4'h0;
    end else if (cs_hi) begin
      drv_q <= 4'h0;
      en_q <= 4'h0;
      out_cnt_q <= 4'h0;
    end else if (out_edge) begin
      drv_q <= drv_d;
      en_q <= en_d;
      out_sr_q <= src << data_lines_q;
      out_cnt_q <= ((out_cnt_q == 4'h0) ? OUT_BYTE : out_cnt_q) - {1'b0, data_lines_q};
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      busy_q <= 1'b0;
    end else begin
      busy_q <= !cs_hi;
    end
  end

  assign serial_io_lines_drv = drv_q;
  assign serial_io_lines_en = en_q;
  assign array_rd = rd_q;
  assign array_addr = array_addr_q;
  assign busy = busy_q;

  deselect_release_a: assert property (@(posedge clk) disable iff (!nrst)
    cs_hi |=> ((en_q == 4'h0) && (state_q == ST_IDLE)) ##1 (en_q == 4'h0))
    else $error("lines still driven after deselect");

  basic_nodummy_a: assert property (@(posedge clk) disable iff (!nrst)
    addr_done && !cmd_q.fast && !cmd_q.word && !cs_hi |=> state_q == ST_DATA)
    else $error("basic read did not go straight to data");

  word_dummy_a: assert property (@(posedge clk) disable iff (!nrst)
    addr_done && cmd_q.word && !cs_hi |=> state_q == ST_DUMMY && dummy_q == DUMMY_WORD)
    else $error("word read dummy count wrong");

  word_refuse_a: assert property (@(posedge clk) disable iff (!nrst)
    opc_done && !cs_hi && in_sr_d[7:0] == OP_WORD && (proto == SNR_DUAL || dtr_en)
    |=> state_q == ST_IGN ##1 (cs_hi || state_q == ST_IGN))
    else $error("word read not ignored");

  force_four_a: assert property (@(posedge clk) disable iff (!nrst)
    opc_done && !cs_hi && cmd.ok && cmd.force4 && !cmd.word |=> addr_bits_q == BITS_4B)
    else $error("4-byte opcode took short address");

  default_three_a: assert property (@(posedge clk) disable iff (!nrst)
    opc_done && !cs_hi && in_sr_d[7:0] == OP_READ && !addr4_q |=> addr_bits_q == BITS_3B)
    else $error("default address width not 24 bits");

  mode_four_a: assert property (@(posedge clk) disable iff (!nrst)
    opc_done && !cs_hi && cmd.ok && !cmd.force4 && addr4_q |=> addr_bits_q == BITS_4B)
    else $error("4-byte mode ignored by ordinary read");

  dtr_forced_a: assert property (@(posedge clk) disable iff (!nrst)
    opc_done && !cs_hi && cmd.dtr |=> dtr_q)
    else $error("both-edge opcode ran single-edge");

  str_default_a: assert property (@(posedge clk) disable iff (!nrst)
    opc_done && !cs_hi && cmd.ok && !cmd.dtr && !dtr_en |=> !dtr_q)
    else $error("single-edge read ran both-edge");

  addr_wrap_a: assert property (@(posedge clk) disable iff (!nrst)
    rd_q && array_addr_q == MEM_LAST && !cs_hi ##1 !cs_hi [*2] ##1 rd_q
    |-> array_addr_q == MEM_FIRST)
    else $error("address did not wrap to zero");

  addr_step_a: assert property (@(posedge clk) disable iff (!nrst)
    rd_q && array_addr_q != MEM_LAST && !cs_hi ##1 !cs_hi [*2] ##1 rd_q
    |-> array_addr_q == $past(array_addr_q, 3) + 25'h1)
    else $error("address did not step by one");

endmodule // snr_read_path

/* File: tb/snr_host_model.sv */
// Purpose: Host controller model that frames reads on chip select, clock and data lines.
// Assumes: Each serial clock half period lasts four clk cycles or more.
// Notes: A line that nobody drives toggles every cycle, so a stale value never passes.
`timescale 1ns/1ps
module snr_host_model (
  input wire logic clk,
  output logic sclk,
  output logic cs_n,
  output logic [3:0] io_wire,
  input wire logic [3:0] dev_drv,
  input wire logic [3:0] dev_en
);
  logic [3:0] h_drv = 4'h0;
  logic [3:0] h_en = 4'h0;
  logic [3:0] junk = 4'h5;
  logic [3:0] oe = 4'h0;
  logic [7:0] rb [0:3];
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
  end
  always @(posedge clk) junk <= ~junk;
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      io_wire[i] = dev_en[i] ? dev_drv[i] : (h_en[i] ? h_drv[i] : junk[i]);
    end
  end
  task automatic tick();
    repeat (4) @(negedge clk);
    sclk = ~sclk;
  endtask
  // Single-edge steps need a rising edge; both-edge steps move on every edge
  task automatic send(input logic [31:0] v, input int nb, input int ln, input bit both);
    h_en = 4'((1 << ln) - 1);
    for (int i = nb - ln; i >= 0; i -= ln) begin
      if (!both && sclk) tick();
      // Both-edge data moves between edges so no edge sees it change
      if (both) repeat (2) @(negedge clk);
      h_drv = 4'((v >> i) & ((1 << ln) - 1));
      tick();
    end
  endtask
  task automatic frame(input logic [7:0] op, input int ol, input logic [31:0] a, input int ab,
      input int al, input int dm, input int dl, input bit bo, input bit ba, input int n);
    @(negedge clk);
    cs_n = 1'b0;
    repeat (4) @(negedge clk);
    send(op, 8, ol, bo);
    send(a, ab, al, ba);
    // Hold the last address bit past its edge before letting go
    repeat (2) @(negedge clk);
    h_en = 4'h0;
    // Dummies are rising edges; from a low clock the last fall already carries data
    repeat (2 * dm - int'(!sclk)) tick();
    for (int k = 0; k < n; k++) begin
      for (int i = 0; i < 8; i += dl) begin
        tick();
        repeat (6) @(negedge clk);
        oe = dev_en;
        rb[k] = (rb[k] << dl) | 8'((dl == 1) ? io_wire[1] : io_wire & 4'((1 << dl) - 1));
        if (!ba) tick();
      end
    end
    // One more falling edge lets the device start a byte that is then cut off
    if (sclk) tick();
    repeat (4) @(negedge clk);
    cs_n = 1'b1;
    repeat (8) @(negedge clk);
  endtask
endmodule // snr_host_model

/* File: tb/snr_read_path_tb_top.sv */
// Purpose: Self-checking bench for the serial read path and its prefetch FIFO.
// Assumes: The host model paces the serial clock well below the system clock.
// Notes: Array contents are a fixed function of the address.
`timescale 1ns/1ps
module snr_read_path_tb_top;
  import snr_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic sclk;
  logic cs_n;
  logic [3:0] io_wire;
  logic [3:0] drv;
  logic [3:0] en;
  snr_proto_t proto = SNR_EXT;
  logic dtr_en = 1'b0;
  logic a4_on = 1'b0;
  logic a4_off = 1'b0;
  logic dvset = 1'b0;
  logic array_rd;
  logic busy;
  logic [ADDR_W-1:0] array_addr;
  logic [7:0] adat = 8'h00;
  logic [3:0] dnv = 4'h2;
  int nrd = 0;
  int fails = 0;
  int total_checks = 0;
  int cyc = 0;
  always #50 clk = ~clk;
  snr_host_model host_u (.clk(clk), .sclk(sclk), .cs_n(cs_n), .io_wire(io_wire),
    .dev_drv(drv), .dev_en(en));
  snr_read_path dut_u (.clk(clk), .nrst(nrst), .sclk(sclk), .cs_n(cs_n),
    .serial_io_lines_rx(io_wire), .serial_io_lines_drv(drv), .serial_io_lines_en(en),
    .proto(proto), .dtr_en(dtr_en), .addr4_nv(1'b0), .addr4_enter(a4_on),
    .addr4_exit(a4_off), .dummy_nv(dnv), .dummy_vol(4'h5), .dummy_vol_set(dvset),
    .array_rd(array_rd), .array_addr(array_addr), .array_data(adat), .busy(busy));
  always @(posedge clk) if (array_rd) nrd <= nrd + 1;
  function automatic logic [7:0] mem(input logic [24:0] a);
    return a[7:0] ^ a[15:8] ^ a[23:16] ^ {7'h0, a[24]};
  endfunction
  always @(posedge clk) if (array_rd) adat <= mem(array_addr);
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: byte %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk4(input logic [3:0] got, input logic [3:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: enables %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [7:0] op, input int ol, input logic [31:0] a, input int ab,
      input int al, input int dm, input int dl, input bit bo, input bit ba, input int n,
      input logic [3:0] oe_x, input logic [24:0] a_x);
    host_u.frame(op, ol, a, ab, al, dm, dl, bo, ba, n);
    chk4(host_u.oe, oe_x);
    for (int k = 0; k < n && oe_x != 4'h0; k++) begin
      chk8(host_u.rb[k], mem(a_x + 25'(k)));
    end
    chk4(en, 4'h0);
    chk4({3'h0, busy}, 4'h0);
  endtask
  task automatic t_decode();
    logic [7:0] ops [20] = '{8'h03, 8'h13, 8'h0b, 8'h0c, 8'h3b, 8'h3c, 8'hbb, 8'hbc, 8'h6b,
      8'h6c, 8'heb, 8'hec, 8'h0d, 8'h3d, 8'hbd, 8'h6d, 8'hed, 8'h0e, 8'hbe, 8'hee};
    // Bit 6 fast, bit 5 both-edge, bit 4 four-byte, bit 3 I/O, bits 2:0 lines
    logic [7:0] att [20] = '{8'h01, 8'h11, 8'h41, 8'h51, 8'h42, 8'h52, 8'h4a, 8'h5a, 8'h44,
      8'h54, 8'h4c, 8'h5c, 8'h61, 8'h62, 8'h6a, 8'h64, 8'h6c, 8'h71, 8'h7a, 8'h7c};
    int ln;
    logic [31:0] a;
    for (int i = 0; i < 20; i++) begin
      ln = int'(att[i][2:0]);
      a = 32'h0100_0040 + 32'(i * 5);
      rd(ops[i], 1, a, att[i][4] ? 32 : 24, att[i][3] ? ln : 1, att[i][6] ? 2 : 0, ln, 1'b0,
        att[i][5], 2, (ln == 1) ? OE_1 : ((ln == 2) ? OE_2 : OE_4),
        att[i][4] ? a[24:0] : {1'b0, a[23:0]});
    end
    $display("decode done at %0t", $time);
  endtask
  task automatic t_wrap();
    rd(8'h13, 1, 32'h01ff_fffe, 32, 1, 0, 1, 1'b0, 1'b0, 3, OE_1, 25'h1fffffe);
    $display("wrap done at %0t", $time);
  endtask
  task automatic t_mode();
    @(negedge clk) a4_on = 1'b1;
    @(negedge clk) a4_on = 1'b0;
    rd(8'h03, 1, 32'h0100_0010, 32, 1, 0, 1, 1'b0, 1'b0, 2, OE_1, 25'h1000010);
    @(negedge clk) a4_off = 1'b1;
    @(negedge clk) a4_off = 1'b0;
    rd(8'h03, 1, 32'h0012_3456, 24, 1, 0, 1, 1'b0, 1'b0, 2, OE_1, 25'h0123456);
    @(negedge clk) dvset = 1'b1;
    rd(8'h0b, 1, 32'h0000_0200, 24, 1, 5, 1, 1'b0, 1'b0, 2, OE_1, 25'h200);
    @(negedge clk) dvset = 1'b0;
    $display("mode done at %0t", $time);
  endtask
  task automatic t_proto();
    @(negedge clk) proto = SNR_QUAD;
    rd(8'heb, 4, 32'h0000_0300, 24, 4, 2, 4, 1'b0, 1'b0, 2, OE_4, 25'h300);
    rd(8'he7, 4, 32'h0000_0402, 24, 4, 4, 4, 1'b0, 1'b0, 2, OE_4, 25'h402);
    @(negedge clk) proto = SNR_DUAL;
    rd(8'hbb, 2, 32'h0000_0500, 24, 2, 2, 2, 1'b0, 1'b0, 2, OE_2, 25'h500);
    rd(8'he7, 2, 32'h0000_0600, 24, 2, 4, 2, 1'b0, 1'b0, 1, 4'h0, 25'h0);
    @(negedge clk) proto = SNR_EXT;
    rd(8'he7, 1, 32'h0000_0904, 24, 4, 4, 4, 1'b0, 1'b0, 2, OE_4, 25'h904);
    @(negedge clk) dtr_en = 1'b1;
    rd(8'h0b, 1, 32'h0000_0700, 24, 1, 2, 1, 1'b1, 1'b1, 2, OE_1, 25'h700);
    rd(8'he7, 1, 32'h0000_0800, 24, 4, 4, 4, 1'b1, 1'b1, 1, 4'h0, 25'h0);
    @(negedge clk) dtr_en = 1'b0;
    $display("protocol done at %0t", $time);
  endtask
  // Eight default dummies let the prefetch fill the FIFO before the first byte leaves
  task automatic t_fill();
    int n0;
    n0 = nrd;
    @(negedge clk) dnv = 4'h0;
    rd(8'h0b, 1, 32'h0000_01f0, 24, 1, 8, 1, 1'b0, 1'b0, 3, OE_1, 25'h1f0);
    // A full FIFO, then one refill per byte popped, the cut byte included
    chk8(8'(nrd - n0), 8'(FIFO_D + 4));
    chk8(array_addr[7:0], 8'(32'h1f0 + FIFO_D + 3));
    @(negedge clk) dnv = 4'h2;
    $display("fill done at %0t", $time);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Ceiling sits well above the few tens of frames the tests run
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      fails++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (16) @(negedge clk);
    nrst = 1'b1;
    repeat (4) @(negedge clk);
    t_decode();
    t_wrap();
    t_mode();
    t_proto();
    t_fill();
    tally_and_finish();
  end
endmodule // snr_read_path_tb_top
